// *** design/trig_seq_regs.vh ***
/*
 * Constants of the trigger sequencer: register offsets, field positions,
 * reset values and timing figures.
 * Assumes inclusion by bare name from design files of this block.
 */
`ifndef TRIG_SEQ_REGS_VH
`define TRIG_SEQ_REGS_VH

// Register byte offsets
`define OFF_MODE_REG_ZERO 12'h000
`define OFF_MODE1 12'h004
`define OFF_STOP 12'h008
`define OFF_PAGE 12'h00c
`define OFF_CFG 12'h010
`define OFF_EN 12'h014
`define OFF_STATUS 12'h018
`define OFF_INT_STAT 12'h01c
`define OFF_INT_MASK 12'h020
`define OFF_CMD 12'h024
`define OFF_ROW_SEL 12'h028

// Reset values
`define RST_MODE 8'hff
`define RST_STOP 5'h1f
`define RST_PAGE 5'h00
`define RST_CFG 8'h00
`define RST_EN 8'hff
`define RST_MASK 10'h000
`define RST_SAMPLE 8'h80

// Mode register 0 fields
`define M0_LED_FLASH 7
`define M0_LEDB_SEL 6
`define M0_DEB_LONG 4
`define M0_STOPA_SEL 2
// Mode register 1 fields
`define M1_LED_ALT 5
`define M1_LED1_SECT 4

// Config register fields
`define CFG_RATE_LSB 0
`define CFG_RATE_MSB 1
`define CFG_PWM 2
`define CFG_PMODE_LSB 3
`define CFG_PMODE_MSB 4
`define CFG_LED_ON 5

// Command register fields
`define CMD_JUMP 0
`define CMD_DONE 1

// Page modes
`define PMODE_1 2'h0
`define PMODE_8 2'h1
`define PMODE_16 2'h2

// Init voice group
`define INIT_GROUP 11'h020

// Timing in microseconds, clock rate in MHz
`define POR_DELAY_US 160000
`define DEB_LONG_US 50000
`define DEB_SHORT_US 400
`define LED_HALF_US 166666
`define CLK_MHZ 40

`endif

// *** design/trig_debounce.v ***
/*
 * Debouncer for one trigger input with rise and fall event pulses.
 * Assumes the input is already synchronised to pclk.
 */
`timescale 1ns/1ps
module trig_debounce #(
    parameter CW = 21
) (
    input wire pclk,
    input wire presetn,
    input wire din,
    input wire [CW-1:0] limit,
    output reg level_r,
    output reg rise_r,
    output reg fall_r
);
    reg [CW-1:0] cnt_r;

    // Level accepted only after it holds for limit+1 cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {CW{1'b0}};
            level_r <= 1'b1;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (din == level_r) begin
                cnt_r <= {CW{1'b0}};
            end else if (cnt_r >= limit) begin
                cnt_r <= {CW{1'b0}};
                level_r <= din;
                rise_r <= din;
                fall_r <= ~din;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule

// *** design/speech_trigger_sequencer.v ***
/*
 * Control sequencer: power-on delay and init program, debounced triggers
 * with matrix scan, priority grant, stop/busy/LED pins, audio form select.
 * Assumes an APB master on pclk and trigger pins from outside the domain.
 */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "trig_seq_regs.vh"

module speech_trigger_sequencer #(
    parameter POR_CYCLES = `POR_DELAY_US * `CLK_MHZ,
    parameter DEB_LONG_CYCLES = `DEB_LONG_US * `CLK_MHZ,
    parameter DEB_SHORT_CYCLES = `DEB_SHORT_US * `CLK_MHZ,
    parameter LED_HALF_CYCLES = `LED_HALF_US * `CLK_MHZ,
    parameter NROW = 6
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] trig_pin,
    output reg [NROW-1:0] scan_row_r,
    output reg led_a_r,
    output reg stop_a_or_busy_pin,
    output reg stop_b_out,
    output reg led_b_or_stop_c_pin,
    output reg stop_d_out,
    output reg stop_e_out,
    output reg audio_pos_out,
    output reg audio_neg_out,
    output reg grant_valid_r,
    output reg [3:0] grant_id_r,
    output reg [10:0] grant_group_r,
    output reg irq_r
);
    localparam CW = 24;
    localparam NREQ = 10;
    localparam ST_POR = 2'h0;
    localparam ST_INIT = 2'h1;
    localparam ST_RUN = 2'h2;

    // Software visible registers and internal state
    reg [7:0] mode_reg_zero_r;
    reg [7:0] mode1_r;
    reg [4:0] stop_r;
    reg [4:0] page_r;
    reg [7:0] cfg_r;
    reg [7:0] en_r;
    reg [NREQ-1:0] int_stat_r;
    reg [NREQ-1:0] int_mask_r;
    reg [1:0] state_r;
    reg [CW-1:0] por_cnt_r;
    reg [NREQ-1:0] pend_r;
    reg busy_r;
    reg [2:0] row_r;
    reg [7:0] jump_group_r;
    reg [CW-1:0] led_cnt_r;
    reg led_ph_r;
    reg [7:0] pwm_cnt_r;
    reg [7:0] sample_r;
    reg [3:0] sync1_r;
    reg [3:0] sync2_r;
    reg [4*NROW-1:0] key_r;

    wire [3:0] lvl;
    wire [3:0] rise;
    wire [3:0] fall;
    wire [CW-1:0] deb_limit;
    wire wr_en;
    wire rd_en;
    wire jump_wr;
    wire done_wr;
    wire [NREQ-1:0] new_req;
    wire [NREQ-1:0] all_req;
    reg [NREQ-1:0] win;
    reg [3:0] win_id;
    reg [10:0] grp_nxt;
    integer k;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign jump_wr = wr_en && (paddr == `OFF_CMD) && pwdata[`CMD_JUMP];
    assign done_wr = wr_en && (paddr == `OFF_CMD) && pwdata[`CMD_DONE];

    // Debounce time chosen by mode 0 bit 4
    assign deb_limit = mode_reg_zero_r[`M0_DEB_LONG] ? DEB_LONG_CYCLES[CW-1:0]
                                             : DEB_SHORT_CYCLES[CW-1:0];

    // Two-stage pin synchroniser
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 4'hf;
            sync2_r <= 4'hf;
        end else begin
            sync1_r <= trig_pin;
            sync2_r <= sync1_r;
        end
    end

    // One debouncer per direct trigger
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : deb
            trig_debounce #(.CW(CW)) u_deb (
                .pclk(pclk),
                .presetn(presetn),
                .din(sync2_r[g]),
                .limit(deb_limit),
                .level_r(lvl[g]),
                .rise_r(rise[g]),
                .fall_r(fall[g])
            );
        end
    endgenerate

    // Matrix scan: row walks when the low ten bits of the LED counter are zero, keys latched per row
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_r <= 3'h0;
            scan_row_r <= {NROW{1'b1}};
            key_r <= {4*NROW{1'b1}};
        end else begin
            if (led_cnt_r[9:0] == 10'h000) begin
                key_r[row_r*4 +: 4] <= lvl;
                row_r <= (row_r == NROW - 1) ? 3'h0 : row_r + 3'h1;
            end
            scan_row_r <= ~({{(NROW-1){1'b0}}, 1'b1} << row_r);
        end
    end

    // Request vector, index 0 highest: init, t1f,t1r,t2f,t2r,t5f,t5r,t6f,t6r, jump
    assign new_req = {jump_wr,
                      rise[3] & en_r[5], fall[3] & en_r[1],
                      rise[2] & en_r[4], fall[2] & en_r[0],
                      rise[1] & en_r[5], fall[1] & en_r[1],
                      rise[0] & en_r[4], fall[0] & en_r[0],
                      1'b0};
    assign all_req = pend_r | new_req;

    // Fixed priority pick, lowest index wins
    always @* begin
        win = {NREQ{1'b0}};
        win_id = 4'h0;
        for (k = NREQ - 1; k >= 0; k = k - 1) begin
            if (all_req[k]) begin
                win = {NREQ{1'b0}};
                win[k] = 1'b1;
                win_id = k[3:0];
            end
        end
    end

    // Group address of the winner, masked by page mode
    always @* begin
        if (win_id == 4'h0) begin
            grp_nxt = `INIT_GROUP;
        end else if (win_id == 4'h9) begin
            grp_nxt = {3'h0, jump_group_r};
        end else begin
            grp_nxt = {7'h00, win_id};
        end
        case (cfg_r[`CFG_PMODE_MSB:`CFG_PMODE_LSB])
            `PMODE_1: grp_nxt = {3'h0, grp_nxt[7:0]};
            `PMODE_8: grp_nxt = {page_r[2:0], grp_nxt[7:0]};
            `PMODE_16: grp_nxt = {page_r[3:0], grp_nxt[6:0]};
            default: grp_nxt = {page_r[4:0], grp_nxt[5:0]};
        endcase
    end

    // Power-on sequence and grant engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_POR;
            por_cnt_r <= {CW{1'b0}};
            pend_r <= {NREQ{1'b0}};
            busy_r <= 1'b0;
            grant_valid_r <= 1'b0;
            grant_id_r <= 4'h0;
            grant_group_r <= 11'h000;
        end else begin
            grant_valid_r <= 1'b0;
            case (state_r)
                ST_POR: begin
                    pend_r <= pend_r | new_req;
                    if (por_cnt_r >= POR_CYCLES[CW-1:0] - 1'b1) begin
                        state_r <= ST_INIT;
                        pend_r <= pend_r | new_req | {{(NREQ-1){1'b0}}, 1'b1};
                    end else begin
                        por_cnt_r <= por_cnt_r + 1'b1;
                    end
                end
                ST_INIT, ST_RUN: begin
                    if (!busy_r && all_req != {NREQ{1'b0}}) begin
                        pend_r <= all_req & ~win;
                        busy_r <= 1'b1;
                        grant_valid_r <= 1'b1;
                        grant_id_r <= win_id;
                        grant_group_r <= grp_nxt;
                    end else begin
                        pend_r <= all_req;
                    end
                    if (busy_r && done_wr) begin
                        busy_r <= 1'b0;
                        state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_POR;
            endcase
        end
    end

    // LED flash timebase and sample-rate PWM counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_cnt_r <= {CW{1'b0}};
            led_ph_r <= 1'b0;
            pwm_cnt_r <= 8'h00;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 8'h01 + {6'h00, cfg_r[`CFG_RATE_MSB:`CFG_RATE_LSB]};
            if (led_cnt_r >= LED_HALF_CYCLES[CW-1:0] - 1'b1) begin
                led_cnt_r <= {CW{1'b0}};
                led_ph_r <= ~led_ph_r;
            end else begin
                led_cnt_r <= led_cnt_r + 1'b1;
            end
        end
    end

    // Output pins, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_a_r <= 1'b0;
            stop_a_or_busy_pin <= 1'b0;
            stop_b_out <= 1'b0;
            led_b_or_stop_c_pin <= 1'b0;
            stop_d_out <= 1'b0;
            stop_e_out <= 1'b0;
            audio_pos_out <= 1'b0;
            audio_neg_out <= 1'b0;
        end else begin
            led_a_r <= busy_r && cfg_r[`CFG_LED_ON] && mode1_r[`M1_LED1_SECT] &&
                       (!mode_reg_zero_r[`M0_LED_FLASH] || led_ph_r);
            stop_a_or_busy_pin <= mode_reg_zero_r[`M0_STOPA_SEL] ? stop_r[0] : busy_r;
            stop_b_out <= stop_r[1];
            led_b_or_stop_c_pin <= mode_reg_zero_r[`M0_LEDB_SEL] ?
                (busy_r && cfg_r[`CFG_LED_ON] &&
                 (!mode_reg_zero_r[`M0_LED_FLASH] || (led_ph_r ^ mode1_r[`M1_LED_ALT]))) : stop_r[2];
            stop_d_out <= stop_r[3];
            stop_e_out <= stop_r[4];
            if (cfg_r[`CFG_PWM]) begin
                audio_pos_out <= busy_r && (pwm_cnt_r < sample_r);
                audio_neg_out <= busy_r && (pwm_cnt_r >= sample_r);
            end else begin
                audio_pos_out <= busy_r && sample_r[7];
                audio_neg_out <= 1'b0;
            end
        end
    end

    // APB register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg_zero_r <= `RST_MODE;
            mode1_r <= `RST_MODE;
            stop_r <= `RST_STOP;
            page_r <= `RST_PAGE;
            cfg_r <= `RST_CFG;
            en_r <= `RST_EN;
            int_mask_r <= `RST_MASK;
            jump_group_r <= 8'h00;
            sample_r <= `RST_SAMPLE;
        end else if (wr_en) begin
            case (paddr)
                `OFF_MODE_REG_ZERO: mode_reg_zero_r <= pwdata[7:0];
                `OFF_MODE1: mode1_r <= pwdata[7:0];
                `OFF_STOP: stop_r <= pwdata[4:0];
                `OFF_PAGE: page_r <= pwdata[4:0];
                `OFF_CFG: cfg_r <= pwdata[7:0];
                `OFF_EN: en_r <= pwdata[7:0];
                `OFF_INT_MASK: int_mask_r <= pwdata[NREQ-1:0];
                `OFF_CMD: begin
                    jump_group_r <= pwdata[15:8];
                    sample_r <= pwdata[23:16];
                end
                default: ;
            endcase
        end
    end

    // Sticky grant events, write one to clear, set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= {NREQ{1'b0}};
            irq_r <= 1'b0;
        end else begin
            if (wr_en && paddr == `OFF_INT_STAT) begin
                int_stat_r <= (int_stat_r & ~pwdata[NREQ-1:0]) |
                              (grant_valid_r ? ({{(NREQ-1){1'b0}}, 1'b1} << grant_id_r) :
                               {NREQ{1'b0}});
            end else if (grant_valid_r) begin
                int_stat_r <= int_stat_r | ({{(NREQ-1){1'b0}}, 1'b1} << grant_id_r);
            end
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    // APB read path and answer, ready in access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `OFF_MODE_REG_ZERO: prdata <= {24'h000000, mode_reg_zero_r};
                    `OFF_MODE1: prdata <= {24'h000000, mode1_r};
                    `OFF_STOP: prdata <= {27'h0, stop_r};
                    `OFF_PAGE: prdata <= {27'h0, page_r};
                    `OFF_CFG: prdata <= {24'h000000, cfg_r};
                    `OFF_EN: prdata <= {24'h000000, en_r};
                    `OFF_STATUS: prdata <= {12'h000, grant_group_r, 2'h0, lvl, busy_r, state_r};
                    `OFF_INT_STAT: prdata <= {22'h0, int_stat_r};
                    `OFF_INT_MASK: prdata <= {22'h0, int_mask_r};
                    `OFF_ROW_SEL: prdata <= {8'h00, key_r};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// *** sim/seq_chk.sv ***
/* Concurrent checks on the trigger sequencer top-level ports.
   Bound from the bench top file; one clock, active-low async reset. */
`timescale 1ns/1ps
`include "trig_seq_regs.vh"
module seq_chk #(
    parameter POR_CYCLES = 50,
    parameter NROW = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NROW-1:0] scan_row_r,
    input wire logic stop_b_out,
    input wire logic grant_valid_r,
    input wire logic [3:0] grant_id_r,
    input wire logic [10:0] grant_group_r
);
    reg [31:0] age_r;
    reg busy_r;
    reg any_r;
    reg stopb_r;
    wire acc = psel && penable && pready;
    wire stop_wr = acc && pwrite && paddr == `OFF_STOP;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Age since release, owner flag, first-grant flag, last stop B value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= 32'h0;
            busy_r <= 1'b0;
            any_r <= 1'b0;
            stopb_r <= 1'b0;
        end else begin
            if (age_r != 32'hffffffff) age_r <= age_r + 32'h1;
            if (grant_valid_r) any_r <= 1'b1;
            if (grant_valid_r) busy_r <= 1'b1;
            else if (acc && pwrite && paddr == `OFF_CMD && pwdata[1]) busy_r <= 1'b0;
            if (stop_wr) stopb_r <= pwdata[1];
        end
    end
    chk_grant_pulse: assert property (grant_valid_r |=> !grant_valid_r)
        else $error("grant pulse longer than a cycle");
    chk_single_owner: assert property (grant_valid_r |-> !busy_r)
        else $error("grant while previous one still busy");
    chk_grant_id: assert property (grant_valid_r |-> grant_id_r <= 4'h9)
        else $error("grant id outside table");
    chk_init_first: assert property (grant_valid_r && !any_r |-> grant_id_r == 4'h0)
        else $error("first grant after reset not init");
    chk_init_group: assert property (grant_valid_r && grant_id_r == 4'h0
        |-> grant_group_r == `INIT_GROUP)
        else $error("init grant group wrong");
    chk_por_wait: assert property (grant_valid_r |-> age_r >= POR_CYCLES - 1)
        else $error("grant before power-on delay");
    chk_stop_b: assert property (stop_wr |-> ##2 stop_b_out == stopb_r)
        else $error("stop B pin not following register");
    chk_scan_hot: assert property ($countones(~scan_row_r) <= 1)
        else $error("more than one scan row driven");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than a cycle");
    chk_no_slverr: assert property (!pslverr)
        else $error("slave error raised");
endmodule

// *** sim/trig_switches.sv ***
/* Trigger switch model: four lines pulled high, closed to ground.
   Tasks are called just after a pclk edge. */
`timescale 1ns/1ps
module trig_switches (
    input wire logic pclk,
    output logic [3:0] trig_pin
);
    // Pull-ups hold every line high while open
    initial trig_pin = 4'hf;
    // Set all lines, then let one edge pass
    task set_lines(input [3:0] v);
        begin
            trig_pin <= v;
            @(posedge pclk);
        end
    endtask
    // Close one line for n cycles, as a bounce or short tap
    task press(input integer k, input integer n);
        begin
            trig_pin[k] <= 1'b0;
            repeat (n) @(posedge pclk);
            trig_pin[k] <= 1'b1;
            @(posedge pclk);
        end
    endtask
endmodule

// *** sim/speech_trigger_sequencer_test.sv ***
/* Bench for the trigger sequencer: APB tasks, switch model on the
   trigger lines, checker bound below. Shortened delays throughout. */
`timescale 1ns/1ps
`include "trig_seq_regs.vh"
module speech_trigger_sequencer_test;
    localparam POR = 50;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire [3:0] trig_pin;
    wire pready, pslverr, stop_a, stop_b, led_b, stop_d, stop_e;
    wire grant_valid_r, irq_r;
    wire [5:0] scan_row;
    wire led_a, audio_pos, audio_neg;
    wire [3:0] grant_id_r;
    wire [10:0] grant_group_r;
    integer n_mismatch = 0;
    integer checks_done = 0;
    integer wait_n;
    reg [31:0] rd;
    reg [10:0] ggrp;
    always #12.5 pclk = ~pclk;
    trig_switches u_sw (.pclk(pclk), .trig_pin(trig_pin));
    speech_trigger_sequencer #(.POR_CYCLES(POR), .DEB_LONG_CYCLES(20),
        .DEB_SHORT_CYCLES(5), .LED_HALF_CYCLES(64)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin), .scan_row_r(scan_row),
        .led_a_r(led_a), .stop_a_or_busy_pin(stop_a), .stop_b_out(stop_b),
        .led_b_or_stop_c_pin(led_b), .stop_d_out(stop_d), .stop_e_out(stop_e),
        .audio_pos_out(audio_pos), .audio_neg_out(audio_neg), .grant_valid_r(grant_valid_r),
        .grant_id_r(grant_id_r), .grant_group_r(grant_group_r), .irq_r(irq_r));
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    // One APB transfer, then one idle edge; only the watchdog ends a hung wait
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, e);
        end
    endtask
    // Wait for a grant pulse, bounded, and compare its id
    task grant(input [3:0] id);
        begin
            wait_n = 0;
            while (grant_valid_r !== 1'b1 && wait_n < 200) begin
                wait_n = wait_n + 1;
                @(posedge pclk);
            end
            if (wait_n == 200) chk(32'h1, 32'h0);
            ggrp = grant_group_r;
            chk({28'h0, grant_id_r}, {28'h0, id});
        end
    endtask
    // End the current owner, expect the next winner
    task nxt(input [3:0] id);
        begin
            apb(1'b1, `OFF_CMD, 32'h2);
            grant(id);
        end
    endtask
    // No grant may appear for n cycles
    task quiet(input integer n);
        repeat (n) begin
            @(posedge pclk);
            if (grant_valid_r !== 1'b0) chk({28'h0, grant_id_r}, 32'hf);
        end
    endtask
    task final_report;
        begin
            $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
            if (n_mismatch == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Watchdog against a hung handshake
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        final_report;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        grant(4'h0);
        chk({31'h0, wait_n >= POR - 1 && wait_n <= POR + 4}, 32'h1);
        chk({21'h0, ggrp}, 32'h20);
        rdchk(`OFF_MODE_REG_ZERO, 32'hff);
        rdchk(`OFF_STOP, 32'h1f);
        rdchk(`OFF_EN, 32'hff);
        rdchk(`OFF_INT_MASK, 32'h0);
        rdchk(12'h100, 32'h0);
        rdchk(`OFF_ROW_SEL, 32'hffffff);
        chk({31'h0, $countones(~scan_row) == 1}, 32'h1);
        chk({30'h0, audio_pos, audio_neg}, 32'h2);
        chk({28'h0, stop_a, stop_b, stop_d, stop_e}, 32'hf);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk({31'h0, rd[2]}, 32'h1);
        // Shared pins: busy, then stop A and stop C
        apb(1'b1, `OFF_STOP, 32'h0);
        // Pins follow a write by the idle edge that ends the task
        apb(1'b1, `OFF_MODE_REG_ZERO, 32'hfb);
        @(posedge pclk);
        chk({31'h0, stop_a}, 32'h1);
        apb(1'b1, `OFF_MODE_REG_ZERO, 32'hbf);
        @(posedge pclk);
        chk({30'h0, stop_a, led_b}, 32'h0);
        apb(1'b1, `OFF_STOP, 32'h5);
        @(posedge pclk);
        chk({30'h0, stop_a, led_b}, 32'h3);
        // Steady LEDs and PWM pair while the init owner plays
        apb(1'b1, `OFF_CFG, 32'h24);
        apb(1'b1, `OFF_MODE_REG_ZERO, 32'h7f);
        @(posedge pclk);
        chk({29'h0, led_a, led_b, audio_pos ^ audio_neg}, 32'h7);
        apb(1'b1, `OFF_CFG, 32'h0);
        @(posedge pclk);
        chk({29'h0, led_a, audio_pos, audio_neg}, 32'h2);
        apb(1'b1, `OFF_MODE_REG_ZERO, 32'hff);
        // Init status bit stays masked
        apb(1'b1, `OFF_INT_MASK, 32'h2);
        chk({31'h0, irq_r}, 32'h0);
        rdchk(`OFF_INT_STAT, 32'h1);
        // Two falls and a jump all pending behind the init owner
        u_sw.set_lines(4'hc);
        apb(1'b1, `OFF_CMD, 32'h5a01);
        quiet(40);
        nxt(4'h1);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq_r}, 32'h1);
        apb(1'b1, `OFF_INT_STAT, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq_r}, 32'h0);
        nxt(4'h3);
        // Every command write reloads the jump group, so done carries it too
        apb(1'b1, `OFF_CMD, 32'h5a02);
        grant(4'h9);
        chk({21'h0, ggrp}, 32'h5a);
        u_sw.set_lines(4'hf);
        quiet(40);
        nxt(4'h2);
        nxt(4'h4);
        apb(1'b1, `OFF_CMD, 32'h2);
        // Long filter ignores a 12-cycle tap, short one a 3-cycle bounce
        u_sw.press(2, 12);
        quiet(60);
        apb(1'b1, `OFF_MODE_REG_ZERO, 32'hef);
        u_sw.press(2, 3);
        quiet(40);
        u_sw.set_lines(4'hb);
        grant(4'h5);
        u_sw.set_lines(4'hf);
        nxt(4'h6);
        apb(1'b1, `OFF_CMD, 32'h2);
        // Mid-run reset behaves as power-on
        apb(1'b1, `OFF_STOP, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        grant(4'h0);
        rdchk(`OFF_STOP, 32'h1f);
        // Init program that ends at once: nothing else is started
        apb(1'b1, `OFF_CMD, 32'h2);
        quiet(20);
        rdchk(`OFF_STATUS, 32'h407a);
        final_report;
    end
endmodule
bind speech_trigger_sequencer seq_chk #(.POR_CYCLES(POR_CYCLES), .NROW(NROW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .scan_row_r(scan_row_r), .stop_b_out(stop_b_out),
    .grant_valid_r(grant_valid_r), .grant_id_r(grant_id_r),
    .grant_group_r(grant_group_r));
